/* design/spf_seq.v */
`timescale 1ns/100ps
`include "spf_defs.vh"
module spf_seq #(
  parameter        ADDR_W       = 18,
  parameter [23:0] T_SECTOR_CYC = `SPF_SECTOR_ERASE_CYC,
  parameter [23:0] T_BLOCK_CYC  = `SPF_BLOCK_ERASE_CYC,
  parameter [23:0] T_CHIP_CYC   = `SPF_CHIP_ERASE_CYC
) (
  // clock and reset
  input  wire              mclk,
  input  wire              resetn,
  // serial pins
  input  wire              ce_n,
  input  wire              sck,
  input  wire              si,
  output reg               so,
  output reg               so_oe,
  // array program port
  output reg               prog_stb,
  output reg  [ADDR_W-1:0] prog_addr,
  output reg  [15:0]       prog_data,
  // array erase port
  output reg               erase_stb,
  output reg  [ADDR_W-1:0] erase_addr,
  output reg  [1:0]        erase_size,
  // state
  output wire              busy,
  output wire              write_enable_latch,
  output wire              auto_inc_active,
  output wire              busy_out_en
);

  localparam [23:0] T_PROG_CYC = `SPF_WORD_PROG_CYC;

  // protection: bp selects the top quarter, top half or the whole array
  function prot_hit;
    input [1:0] top2;
    input [1:0] bp;
    begin
      case (bp)
        2'h0:    prot_hit = 1'b0;
        2'h1:    prot_hit = (top2 == 2'h3);
        2'h2:    prot_hit = top2[1];
        default: prot_hit = 1'b1;
      endcase
    end
  endfunction

  // pin synchronisers
  wire [2:0] pin_s;
  spf_sync #(.W(3)) u_sync (
    .mclk     (mclk),
    .resetn   (resetn),
    .async_in ({ce_n, sck, si}),
    .rst_val  (3'h7),
    .sync_out (pin_s)
  );
  wire ce_n_s = pin_s[2];
  wire sck_s  = pin_s[1];
  wire si_s   = pin_s[0];

  // frame receive state
  reg        ce_n_prev_q;
  reg        sck_prev_q;
  reg [2:0]  bit_cnt_q;
  reg [2:0]  nbytes_q;
  reg [6:0]  sh_q;
  reg [7:0]  opcode_q;
  reg [39:0] col_q;
  reg        ignore_q;
  // status shift-out
  reg        rd_mode_q;
  reg        rd_sel1_q;
  reg [2:0]  rd_bit_q;
  reg [7:0]  rd_byte_q;
  // device state; busy lasts while the countdown is non-zero
  reg        wel_q;
  reg        aai_q;
  reg        aai_end_q;
  reg        hw_busy_q;
  reg [1:0]  bp_q;
  reg [7:0]  status1_q;
  reg [ADDR_W-1:0] ptr_q;
  reg [23:0] busy_cnt_q;

  // pin edges seen through the synchroniser
  wire sel      = ~ce_n_s;
  wire sck_rise = sck_s & ~sck_prev_q;
  wire sck_fall = ~sck_s & sck_prev_q;
  wire ce_rise  = ce_n_s & ~ce_n_prev_q;
  wire busy_w   = (busy_cnt_q != 24'h000000);
  wire [7:0] rx_byte = {sh_q, si_s};

  // status register as read back; bits not modelled read zero
  wire [7:0] status_w;
  assign status_w = {1'b0, aai_q, 2'h0, bp_q[1], bp_q[0], wel_q, busy_w};

  // opcode filter at the end of the first byte
  reg accept;
  always @* begin
    accept = 1'b1;
    if (aai_q) begin
      if (rx_byte == `SPF_OP_AUTO_INC_WORD)
        accept = ~busy_w;
      else if (rx_byte == `SPF_OP_WRITE_DISABLE)
        accept = 1'b1;
      else if (rx_byte == `SPF_OP_STATUS_READ)
        accept = ~hw_busy_q;
      else
        accept = 1'b0;
    end else if (busy_w) begin
      // only status reads and write disable may interrupt a self-timed operation
      accept = (rx_byte == `SPF_OP_STATUS_READ) || (rx_byte == `SPF_OP_STATUS1_READ) ||
               (rx_byte == `SPF_OP_WRITE_DISABLE);
    end
  end

  // word step; the spare top bit catches running off the array end
  wire [ADDR_W:0]   word_step = {{(ADDR_W-1){1'b0}}, 2'h2};

  // next auto-increment pointer and end-of-range check
  wire [ADDR_W:0]   ptr_nxt  = {1'b0, ptr_q} + word_step;
  wire              nxt_end  = ptr_nxt[ADDR_W] | prot_hit(ptr_nxt[ADDR_W-1:ADDR_W-2], bp_q);

  // first word: address bit 0 forced low, pointer set to the word after it
  wire [ADDR_W-1:0] start_a  = {col_q[16+ADDR_W-1:17], 1'b0};
  wire [ADDR_W:0]   start_nx = {1'b0, start_a} + word_step;
  wire              start_end = start_nx[ADDR_W] |
                                prot_hit(start_nx[ADDR_W-1:ADDR_W-2], bp_q);
  wire [ADDR_W-1:0] erase_a  = col_q[ADDR_W-1:0];

  // serial receive, status shift-out and command execution
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ce_n_prev_q <= 1'b1;
      sck_prev_q  <= 1'b1;                                      // synchronised sck resets high too
      bit_cnt_q   <= 3'h0;
      nbytes_q    <= 3'h0;
      sh_q        <= 7'h00;
      opcode_q    <= 8'h00;
      col_q       <= 40'h0000000000;
      ignore_q    <= 1'b0;
      rd_mode_q   <= 1'b0;
      rd_sel1_q   <= 1'b0;
      rd_bit_q    <= 3'h0;
      rd_byte_q   <= 8'h00;
      wel_q       <= 1'b0;
      aai_q       <= 1'b0;
      aai_end_q   <= 1'b0;
      hw_busy_q   <= 1'b0;
      bp_q        <= `SPF_BP_RST;
      status1_q   <= `SPF_STATUS1_RST;
      ptr_q       <= {ADDR_W{1'b0}};
      busy_cnt_q  <= 24'h000000;
      so          <= 1'b1;
      so_oe       <= 1'b0;
      prog_stb    <= 1'b0;
      prog_addr   <= {ADDR_W{1'b0}};
      prog_data   <= 16'h0000;
      erase_stb   <= 1'b0;
      erase_addr  <= {ADDR_W{1'b0}};
      erase_size  <= `SPF_ERASE_SECTOR;
    end else begin
      ce_n_prev_q <= ce_n_s;
      sck_prev_q  <= sck_s;
      prog_stb    <= 1'b0;
      erase_stb   <= 1'b0;
      // self-timed operation countdown holds busy until done
      if (busy_w)
        busy_cnt_q <= busy_cnt_q - 24'h000001;

      // pin drive: busy pin mode wins while auto-increment runs
      if (sel && hw_busy_q && aai_q && !rd_mode_q) begin
        so_oe <= 1'b1;
        so    <= ~busy_w;
      end else begin
        so_oe <= sel & rd_mode_q;
      end

      // deselect drops any partial frame, so a cut byte never executes
      if (!sel) begin
        bit_cnt_q <= 3'h0;
        nbytes_q  <= 3'h0;
        rd_mode_q <= 1'b0;
        rd_bit_q  <= 3'h0;
      end else begin
        // mode 0: sample on rising clock
        if (sck_rise) begin
          sh_q      <= rx_byte[6:0];
          bit_cnt_q <= bit_cnt_q + 3'h1;
          if (bit_cnt_q == 3'h7) begin
            if (nbytes_q != 3'h7)
              nbytes_q <= nbytes_q + 3'h1;
            if (nbytes_q == 3'h0) begin
              opcode_q  <= rx_byte;
              ignore_q  <= ~accept;
              rd_mode_q <= accept && ((rx_byte == `SPF_OP_STATUS_READ) ||
                                      (rx_byte == `SPF_OP_STATUS1_READ));
              rd_sel1_q <= (rx_byte == `SPF_OP_STATUS1_READ);
            end else begin
              col_q <= {col_q[31:0], rx_byte};
            end
          end
        end
        // status bytes leave msb first on falling clock, repeating
        if (sck_fall && rd_mode_q) begin
          rd_bit_q <= rd_bit_q + 3'h1;
          if (rd_bit_q == 3'h0) begin
            rd_byte_q <= rd_sel1_q ? status1_q : status_w;
            so        <= rd_sel1_q ? status1_q[7] : status_w[7];
          end else begin
            so <= rd_byte_q[3'h7 - rd_bit_q];
          end
        end
      end

      // commands take effect only at select release
      if (ce_rise && !ignore_q && nbytes_q != 3'h0 && bit_cnt_q == 3'h0) begin
        case (opcode_q)
          `SPF_OP_WRITE_ENABLE: begin
            if (nbytes_q == 3'h1)
              wel_q <= 1'b1;
          end
          `SPF_OP_WRITE_DISABLE: begin
            if (nbytes_q == 3'h1) begin
              wel_q     <= 1'b0;
              aai_q     <= 1'b0;
              aai_end_q <= 1'b0;
            end
          end
          `SPF_OP_BUSY_OUT_ON: begin
            if (nbytes_q == 3'h1 && !aai_q)
              hw_busy_q <= 1'b1;
          end
          `SPF_OP_BUSY_OUT_OFF: begin
            if (nbytes_q == 3'h1 && !aai_q)
              hw_busy_q <= 1'b0;
          end
          `SPF_OP_STATUS_WRITE: begin
            // byte or word form only; extra bytes cancel the write
            if (wel_q && (nbytes_q == 3'h2 || nbytes_q == 3'h3)) begin
              wel_q <= 1'b0;
              if (nbytes_q == 3'h2) begin
                bp_q <= col_q[`SPF_ST_BP1:`SPF_ST_BP0];
              end else begin
                bp_q      <= col_q[8+`SPF_ST_BP1:8+`SPF_ST_BP0];
                status1_q <= col_q[7:0];
              end
            end
          end
          `SPF_OP_SECTOR_ERASE, `SPF_OP_BLOCK32_ERASE, `SPF_OP_BLOCK64_ERASE: begin
            if (wel_q && nbytes_q == 3'h4 &&
                !prot_hit(erase_a[ADDR_W-1:ADDR_W-2], bp_q)) begin
              wel_q      <= 1'b0;
              erase_stb  <= 1'b1;
              if (opcode_q == `SPF_OP_SECTOR_ERASE) begin
                erase_addr <= {erase_a[ADDR_W-1:`SPF_SECTOR_LSB], {`SPF_SECTOR_LSB{1'b0}}};
                erase_size <= `SPF_ERASE_SECTOR;
                busy_cnt_q <= T_SECTOR_CYC;
              end else if (opcode_q == `SPF_OP_BLOCK32_ERASE) begin
                erase_addr <= {erase_a[ADDR_W-1:`SPF_BLK32_LSB], {`SPF_BLK32_LSB{1'b0}}};
                erase_size <= `SPF_ERASE_BLK32;
                busy_cnt_q <= T_BLOCK_CYC;
              end else begin
                erase_addr <= {erase_a[ADDR_W-1:`SPF_BLK64_LSB], {`SPF_BLK64_LSB{1'b0}}};
                erase_size <= `SPF_ERASE_BLK64;
                busy_cnt_q <= T_BLOCK_CYC;
              end
            end
          end
          `SPF_OP_CHIP_ERASE_A, `SPF_OP_CHIP_ERASE_B: begin
            if (wel_q && nbytes_q == 3'h1 && bp_q == 2'h0) begin
              wel_q      <= 1'b0;
              erase_stb  <= 1'b1;
              erase_addr <= {ADDR_W{1'b0}};
              erase_size <= `SPF_ERASE_CHIP;
              busy_cnt_q <= T_CHIP_CYC;
            end
          end
          `SPF_OP_AUTO_INC_WORD: begin
            if (!aai_q) begin
              // first word carries the address
              if (wel_q && nbytes_q == 3'h6 &&
                  !prot_hit(start_a[ADDR_W-1:ADDR_W-2], bp_q)) begin
                aai_q      <= 1'b1;
                prog_stb   <= 1'b1;
                prog_addr  <= start_a;
                prog_data  <= col_q[15:0];
                ptr_q      <= start_nx[ADDR_W-1:0];
                aai_end_q  <= start_end;
                busy_cnt_q <= T_PROG_CYC;
              end
            end else if (nbytes_q == 3'h3 && !aai_end_q) begin
              // continuation: no address, next two locations
              prog_stb   <= 1'b1;
              prog_addr  <= ptr_q;
              prog_data  <= col_q[15:0];
              ptr_q      <= ptr_nxt[ADDR_W-1:0];
              aai_end_q  <= nxt_end;
              busy_cnt_q <= T_PROG_CYC;
            end
          end
          default: begin
            ignore_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // state outputs
  assign busy               = busy_w;
  assign write_enable_latch = wel_q;
  assign auto_inc_active    = aai_q;
  assign busy_out_en        = hw_busy_q;

endmodule

/* design/spf_sync.v */
`timescale 1ns/100ps
// two-flop synchroniser for a group of pin levels
module spf_sync #(
  parameter W = 3
) (
  // clock and reset
  input  wire         mclk,
  input  wire         resetn,
  // levels
  input  wire [W-1:0] async_in,
  input  wire [W-1:0] rst_val,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // per-bit chain; every flop resets high, the idle level of select
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          meta_q[i] <= 1'b1;
          sync_q[i] <= 1'b1;
        end else begin
          meta_q[i] <= async_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  // a zero in rst_val inverts that bit on the way out; callers pass all ones
  assign sync_out = sync_q ^ ~rst_val;

endmodule

/* pkg/spf_defs.vh */
`ifndef SPF_DEFS_VH
`define SPF_DEFS_VH

// opcodes
`define SPF_OP_SECTOR_ERASE   8'h20
`define SPF_OP_BLOCK32_ERASE  8'h52
`define SPF_OP_BLOCK64_ERASE  8'hD8
`define SPF_OP_CHIP_ERASE_A   8'h60
`define SPF_OP_CHIP_ERASE_B   8'hC7
`define SPF_OP_AUTO_INC_WORD  8'hAD
`define SPF_OP_STATUS_READ    8'h05
`define SPF_OP_STATUS1_READ   8'h35
`define SPF_OP_STATUS_WRITE   8'h01
`define SPF_OP_WRITE_ENABLE   8'h06
`define SPF_OP_WRITE_DISABLE  8'h04
`define SPF_OP_BUSY_OUT_ON    8'h70
`define SPF_OP_BUSY_OUT_OFF   8'h80

// status register field positions
`define SPF_ST_BUSY   0
`define SPF_ST_WEL    1
`define SPF_ST_BP0    2
`define SPF_ST_BP1    3
`define SPF_ST_AAI    6
`define SPF_ST_BPL    7

// reset values
`define SPF_STATUS1_RST  8'h00
`define SPF_BP_RST       2'h0

// erase size codes on erase_size
`define SPF_ERASE_SECTOR  2'h0
`define SPF_ERASE_BLK32   2'h1
`define SPF_ERASE_BLK64   2'h2
`define SPF_ERASE_CHIP    2'h3

// address bits that select sector and blocks
`define SPF_SECTOR_LSB   12
`define SPF_BLK32_LSB    15
`define SPF_BLK64_LSB    16

// self-timed operation times and clock rate
`define SPF_CLK_MHZ              25
`define SPF_WORD_PROG_TIME_US    10
`define SPF_SECTOR_ERASE_TIME_MS 25
`define SPF_BLOCK_ERASE_TIME_MS  25
`define SPF_CHIP_ERASE_TIME_MS   50
`define SPF_WORD_PROG_CYC   (`SPF_WORD_PROG_TIME_US * `SPF_CLK_MHZ)
`define SPF_SECTOR_ERASE_CYC (`SPF_SECTOR_ERASE_TIME_MS * 1000 * `SPF_CLK_MHZ)
`define SPF_BLOCK_ERASE_CYC (`SPF_BLOCK_ERASE_TIME_MS * 1000 * `SPF_CLK_MHZ)
`define SPF_CHIP_ERASE_CYC  (`SPF_CHIP_ERASE_TIME_MS * 1000 * `SPF_CLK_MHZ)

`endif

/* tb/spf_host_model.sv */
`timescale 1ns/100ps
// host controller, mode 0: sck rests low between frames
module spf_host_model (
  // clock
  input  wire  mclk,
  // serial pins
  output logic ce_n,
  output logic sck,
  output logic si,
  input  wire  so,
  input  wire  so_oe
);
  // pin level as the host sees it, floating when not driven
  wire pin = so_oe ? so : 1'bz;

  initial begin
    ce_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // one frame: tx msb first, then nrd bytes in; rx keeps the last two
  task automatic xfer(input logic [7:0] tx[$], input int nrd, output logic [15:0] rx);
    logic [7:0] b;
    rx = 16'h0000;
    @(posedge mclk);
    ce_n <= 1'b0;
    tick(4);
    for (int i = 0; i < tx.size() + nrd; i++) begin
      b = (i < tx.size()) ? tx[i] : 8'h00;
      for (int k = 7; k >= 0; k--) begin
        si <= b[k];
        tick(4);
        sck <= 1'b1;
        tick(4);
        if (i >= tx.size()) rx = {rx[14:0], pin};
        sck <= 1'b0;
      end
    end
    tick(4);
    ce_n <= 1'b1;
    // released data line shows no stale value
    si <= ~si;
    tick(8);
  endtask

  // select without clocks: sample pin, deselect, sample again
  task automatic probe(output logic [1:0] lv);
    @(posedge mclk);
    ce_n <= 1'b0;
    tick(6);
    lv[1] = pin;
    ce_n <= 1'b1;
    tick(6);
    lv[0] = pin;
  endtask
endmodule

/* tb/spf_seq_sva.sv */
`timescale 1ns/100ps
// pin and strobe relations of the sequencer
module spf_seq_chk #(
  parameter ADDR_W = 18
) (
  // clock and reset
  input wire              mclk,
  input wire              resetn,
  // pins
  input wire              ce_n,
  input wire              so,
  input wire              so_oe,
  // array ports
  input wire              prog_stb,
  input wire [ADDR_W-1:0] prog_addr,
  input wire              erase_stb,
  input wire [ADDR_W-1:0] erase_addr,
  input wire [1:0]        erase_size,
  // state
  input wire              busy,
  input wire              write_enable_latch,
  input wire              auto_inc_active,
  input wire              busy_out_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  logic [ADDR_W-1:0] last_q;
  logic              have_q;

  // previous word address, forgotten once the sequence ends
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      last_q <= '0;
      have_q <= 1'b0;
    end else if (prog_stb) begin
      last_q <= prog_addr;
      have_q <= 1'b1;
    end else if (!auto_inc_active) begin
      have_q <= 1'b0;
    end
  end

  AST_EVEN_ADDR: assert property (prog_stb |-> !prog_addr[0])
    else $error("word address is odd");
  AST_WORD_STEP: assert property (prog_stb && have_q |-> prog_addr == last_q + 2)
    else $error("word address did not step by two");
  AST_EXEC_DESELECT: assert property ((prog_stb || erase_stb) |-> ce_n && $past(ce_n) && $past(ce_n, 2))
    else $error("operation started while selected");
  AST_BUSY_HOLDS: assert property ((prog_stb || erase_stb) |=> busy [*8])
    else $error("busy not held after start");
  AST_ONE_OP: assert property ((prog_stb || erase_stb) |-> !$past(busy))
    else $error("operation started while busy");
  AST_LATCH_NEEDED: assert property ((prog_stb || erase_stb) |-> $past(write_enable_latch))
    else $error("operation started without latch");
  AST_FLOAT_IDLE: assert property (ce_n [*5] |-> !so_oe)
    else $error("serial out driven while deselected");
  AST_PIN_BUSY: assert property (so_oe && $past(so_oe) && busy_out_en && auto_inc_active
    && busy && $past(busy, 3) |-> !so)
    else $error("pin shows ready while busy");
  AST_PIN_READY: assert property (so_oe && $past(so_oe) && busy_out_en && auto_inc_active
    && !busy && !$past(busy, 3) |-> so)
    else $error("pin shows busy while ready");
  AST_WRITE_DISABLE_CMD_CLEARS: assert property ($fell(auto_inc_active) |-> !write_enable_latch)
    else $error("latch kept after leaving sequence");
  AST_WRITE_DISABLE_CMD_NO_ABORT: assert property ($fell(write_enable_latch) && $past(busy) |-> busy)
    else $error("write disable aborted operation");
  AST_ERASE_ALIGN: assert property (erase_stb |-> (erase_size == 2'h0) ? erase_addr[11:0] == 12'h000 :
    (erase_size == 2'h1) ? erase_addr[14:0] == 15'h0000 :
    (erase_size == 2'h2) ? erase_addr[15:0] == 16'h0000 : 1'b1)
    else $error("erase base not aligned");
endmodule

/* tb/spi_flash_program_erase_control_tb.sv */
`timescale 1ns/100ps
module spi_flash_program_erase_control_tb;
  logic mclk, resetn;
  wire ce_n, sck, si, so, so_oe, prog_stb, erase_stb, busy, write_enable_latch, auto_inc_active, busy_out_en;
  wire [17:0] prog_addr, erase_addr;
  wire [15:0] prog_data;
  wire [1:0] erase_size;
  logic [17:0] p_addr, e_addr;
  logic [15:0] p_data;
  logic [1:0] e_size;
  int p_cnt, e_cnt, err_count, num_checks;

  // erase times cut short; long enough for a status read to see busy
  spf_seq #(.T_SECTOR_CYC(24'h0007D0), .T_BLOCK_CYC(24'h0007D0), .T_CHIP_CYC(24'h0007D0)) i_dut (
    .mclk, .resetn, .ce_n, .sck, .si, .so, .so_oe, .prog_stb, .prog_addr, .prog_data, .erase_stb,
    .erase_addr, .erase_size, .busy, .write_enable_latch, .auto_inc_active, .busy_out_en);
  spf_host_model i_host (.mclk, .ce_n, .sck, .si, .so, .so_oe);

  // array side: record every strobe
  always @(posedge mclk) begin
    if (prog_stb === 1'b1) begin
      p_cnt <= p_cnt + 1;
      p_addr <= prog_addr;
      p_data <= prog_data;
    end
    if (erase_stb === 1'b1) begin
      e_cnt <= e_cnt + 1;
      e_addr <= erase_addr;
      e_size <= erase_size;
    end
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] tx[$]);
    logic [15:0] rx;
    i_host.xfer(tx, 0, rx);
  endtask

  function automatic logic [7:0] st_now();
    return {auto_inc_active, 5'h00, write_enable_latch, busy};
  endfunction

  // poll status, or the busy pin when pin is set, under a bound
  task automatic wait_idle(input bit use_pin);
    logic [15:0] rx;
    logic [1:0] lv;
    for (int n = 0; n < 400; n++) begin
      if (use_pin) i_host.probe(lv);
      else i_host.xfer('{8'h05}, 1, rx);
      if (use_pin ? lv[1] === 1'b1 : rx[0] === 1'b0) return;
    end
    err_count++;
    report_and_stop();
  endtask

  task automatic t_status;
    logic [15:0] rx;
    i_host.xfer('{8'h05}, 2, rx);
    check(rx, 16'h0000);
    cmd('{8'h06});
    i_host.xfer('{8'h05}, 2, rx);
    check(rx, 16'h0202);
    cmd('{8'h04});
    check(write_enable_latch, 1'b0);
    // word form of the status write fills status register 1
    cmd('{8'h06});
    cmd('{8'h01, 8'h00, 8'h5A});
    i_host.xfer('{8'h35}, 2, rx);
    check(rx, 16'h5A5A);
    check(write_enable_latch, 1'b0);
  endtask

  task automatic t_erase;
    logic [7:0] op[5] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
    logic [17:0] base[5] = '{18'h1A000, 18'h18000, 18'h10000, 18'h00000, 18'h00000};
    logic [1:0] sz[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    logic [15:0] rx;
    int n0;
    for (int i = 0; i < 5; i++) begin
      n0 = e_cnt;
      cmd('{8'h06});
      if (i < 3) cmd('{op[i], 8'hF5, 8'hAB, 8'hCD});
      else cmd('{op[i]});
      i_host.xfer('{8'h05}, 1, rx);
      check(rx[0], 1'b1);
      wait_idle(1'b0);
      check(e_cnt - n0, 24'h000001);
      check(e_size, sz[i]);
      check(e_addr, base[i]);
    end
    n0 = e_cnt;
    cmd('{8'h20, 8'h00, 8'h10, 8'h00});
    cmd('{8'h06});
    cmd('{8'h20, 8'h00, 8'h10});
    check(e_cnt - n0, 24'h000000);
    cmd('{8'h04});
  endtask

  task automatic t_protect;
    logic [15:0] rx;
    int n0 = e_cnt;
    int m0 = p_cnt;
    cmd('{8'h06});
    cmd('{8'h01, 8'h04});
    i_host.xfer('{8'h05}, 1, rx);
    check(rx[7:0], 8'h04);
    cmd('{8'h06});
    cmd('{8'h20, 8'h03, 8'hF0, 8'h00});
    cmd('{8'h60});
    cmd('{8'hAD, 8'h03, 8'h00, 8'h00, 8'h12, 8'h34});
    check(e_cnt - n0, 24'h000000);
    check(p_cnt - m0, 24'h000000);
    cmd('{8'h01, 8'h00});
  endtask

  task automatic t_aai_soft;
    logic [15:0] rx;
    int n0 = e_cnt;
    cmd('{8'h06});
    cmd('{8'hAD, 8'h00, 8'h01, 8'h01, 8'hA5, 8'h5A});
    i_host.xfer('{8'h05}, 1, rx);
    check(rx[7:0], 8'h43);
    wait_idle(1'b0);
    check(p_addr, 18'h00100);
    check(p_data, 16'hA55A);
    cmd('{8'h20, 8'h00, 8'h00, 8'h00});
    check(e_cnt - n0, 24'h000000);
    cmd('{8'hAD, 8'hC3, 8'h3C});
    cmd('{8'h04});
    check(st_now(), 8'h01);
    check(p_addr, 18'h00102);
    check(p_data, 16'hC33C);
    wait_idle(1'b0);
  endtask

  task automatic t_aai_pin;
    logic [15:0] rx;
    logic [1:0] lv;
    int m0;
    cmd('{8'h70});
    check(busy_out_en, 1'b1);
    cmd('{8'h06});
    cmd('{8'hAD, 8'h03, 8'hFF, 8'hFC, 8'h11, 8'h22});
    i_host.probe(lv);
    check(lv, {1'b0, 1'bz});
    wait_idle(1'b1);
    cmd('{8'hAD, 8'h33, 8'h44});
    wait_idle(1'b1);
    check(p_addr, 18'h3FFFE);
    check(p_data, 16'h3344);
    m0 = p_cnt;
    cmd('{8'hAD, 8'h55, 8'h66});
    wait_idle(1'b1);
    check(p_cnt - m0, 24'h000000);
    i_host.xfer('{8'h05}, 1, rx);
    check(rx[7:0], 8'hFF);
    cmd('{8'h04});
    cmd('{8'h80});
    check({busy_out_en, auto_inc_active}, 2'h0);
  endtask

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // reset, then one scenario after another
  initial begin
    resetn = 1'b0;
    {p_cnt, e_cnt, err_count, num_checks} = '0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    t_status();
    t_erase();
    t_protect();
    t_aai_soft();
    t_aai_pin();
    report_and_stop();
  end
endmodule

bind spf_seq spf_seq_chk #(.ADDR_W(ADDR_W)) i_chk (.mclk, .resetn, .ce_n, .so, .so_oe, .prog_stb,
  .prog_addr, .erase_stb, .erase_addr, .erase_size, .busy, .write_enable_latch, .auto_inc_active,
  .busy_out_en);
